// ==== hdl/stop_pkg.sv ====
// Package of constants and carrier types for the stop mode power controller
package stop_pkg;
  // Stabilization time: reset default is 2^15 main clock periods
  localparam int unsigned RST_STAB_EXP = 15;
  localparam int unsigned RST_STAB_CYC = 32768;
  // Width of the shared stabilization counter
  localparam int unsigned STAB_CNT_W = 20;
  localparam logic [STAB_CNT_W-1:0] STAB_CNT_RST = 20'h00000;
  // Width of the programmed stabilization select value
  localparam int unsigned STAB_SEL_W = 3;
  // Shortest programmed interval; each select step doubles it
  localparam logic [STAB_CNT_W-1:0] PROG_STAB_BASE = 20'h00400;
  // Interrupt priority width
  localparam int unsigned PRIO_W = 3;
  localparam logic [PRIO_W-1:0] PRIO_RST = 3'h7;
  // Number of external interrupt pins
  localparam int unsigned EXT_IRQ_N = 7;

  typedef enum logic [3:0] {
    ST_RUN  = 4'h1,
    ST_STOP = 4'h2,
    ST_STAB = 4'h4,
    ST_WAKE = 4'h8
  } pm_state_e;

  // Wake request bundle; the controller takes these as separate ports instead
  typedef struct packed {
    logic nmi;
    logic ext_irq;
    logic periph_irq;
    logic [PRIO_W-1:0] prio;
  } wake_req_s;

  // Peripheral clock selections during stop
  typedef struct packed {
    logic timer8_ext_sel;
    logic sub_sel;
    logic csi_ext_sel;
    logic uart_ext_sel;
  } periph_sel_s;
endpackage

// ==== hdl/stop_mode_power_control.sv ====
// Stop mode power controller: entry, clock gating, wake and stabilization
// Overview of operation
// - Enter stop from run only when mode select is 1 and stop request written 1.
// - In stop the main oscillator halts while the subclock oscillator keeps running.
// - In stop the CPU and peripheral clocks are gated, halting execution.
// - All internal state, registers and RAM are kept unchanged through stop.
// - Peripherals on subclock or external clock pins keep running in stop.
// - Stop ends on NMI, unmasked external or peripheral interrupt, or reset pin.
// - Normal operation resumes only after the full stabilization interval.
// - Any NMI or unmasked maskable request ends stop regardless of priority.
// - A lower-priority waker inside a handler only ends stop and stays pending.
// - A higher-priority waker, NMI included, ends stop and is acknowledged.
// - An NMI wake branches to its handler whatever the global enable.
// - Maskable wake with interrupts disabled continues at the next instruction.
// - Reset pin wake runs exactly the ordinary reset sequence.
// - Eight-bit timers run in stop only with external count input selected.
// - Second H timer, watch timer, second watchdog need subclock selected.
// - Serial channels need external serial clock; the UART its external baud clock.
// - Port pins hold output and direction state for the whole stop.
// - Interrupt wake waits the programmed interval; reset wake waits 2^15 clocks.
// - The interval is counted by the shared watchdog counter to overflow.
`timescale 1ns/1ps
`default_nettype none

module stop_mode_power_control #(
  parameter int unsigned RST_STAB_CYCLES = stop_pkg::RST_STAB_CYC
) (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_srst,
  // Software control bits
  input wire logic i_power_save_select_bit,
  input wire logic i_stop_request_bit,
  input wire logic [stop_pkg::STAB_SEL_W-1:0] i_osc_stabilization_select_reg,
  input wire logic i_irq_globally_enabled,
  input wire logic i_in_isr,
  input wire logic [stop_pkg::PRIO_W-1:0] i_isr_prio,
  // Wake sources (pins are asynchronous)
  input wire logic i_nmi_pin,
  input wire logic [stop_pkg::EXT_IRQ_N-1:0] i_external_irq_pins,
  input wire logic [stop_pkg::EXT_IRQ_N-1:0] i_ext_irq_mask,
  input wire logic i_periph_irq,
  input wire logic [stop_pkg::PRIO_W-1:0] i_wake_prio,
  input wire logic i_reset_pin_wake,
  // Peripheral clock selections
  input wire stop_pkg::periph_sel_s i_periph_sel,
  input wire logic i_subclock_used,
  // Oscillator and clock gating
  output logic o_main_osc_en,
  output logic o_sub_osc_en,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_async_wake_arm,
  // Stop-domain peripheral enables
  output logic o_timer8_run,
  output logic o_subclk_periph_run,
  output logic o_csi_run,
  output logic o_uart_run,
  // Port and state retention
  output logic o_port_hold,
  output logic o_retain,
  // Wake outcome to CPU and interrupt controller
  output logic o_in_stop,
  output logic o_wake_ack,
  output logic o_wake_branch,
  output logic o_wake_pending,
  output logic o_wake_done
);

  // --------------------------------------------------------------
  // State
  // --------------------------------------------------------------
  typedef struct packed {
    stop_pkg::pm_state_e st;
    logic [stop_pkg::STAB_CNT_W-1:0] cnt;
    logic [stop_pkg::STAB_CNT_W-1:0] limit;
    logic ack;
    logic branch;
    logic pend;
    logic done;
    logic nmi_wake;
    logic rst_wake;
    logic [1:0] nmi_sync;
    logic [2*stop_pkg::EXT_IRQ_N-1:0] ext_sync;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  logic nmi_s;
  logic ext_s;
  logic maskable_s;
  logic wake_any;
  logic higher;
  logic [stop_pkg::STAB_CNT_W-1:0] prog_limit;

  // Synchroniser outputs: second stage only
  assign nmi_s = st_r.nmi_sync[1];
  assign ext_s = |(st_r.ext_sync[2*stop_pkg::EXT_IRQ_N-1:stop_pkg::EXT_IRQ_N] & ~i_ext_irq_mask);
  assign maskable_s = ext_s | i_periph_irq;
  assign wake_any = nmi_s | maskable_s;
  // Lower value is a stronger priority; an NMI always outranks
  assign higher = nmi_s | ~i_in_isr | (i_wake_prio < i_isr_prio);
  // Programmed interval is a power-of-two overflow of the shared counter
  // At the largest select value the shifted base still fits the counter
  assign prog_limit = stop_pkg::STAB_CNT_W'(
    (stop_pkg::PROG_STAB_BASE << i_osc_stabilization_select_reg) - 20'h00001);

  // --------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.nmi_sync = {st_r.nmi_sync[0], i_nmi_pin};
    st_nxt.ext_sync = {st_r.ext_sync[stop_pkg::EXT_IRQ_N-1:0], i_external_irq_pins};
    st_nxt.done = 1'b0;
    st_nxt.ack = 1'b0;
    st_nxt.branch = 1'b0;
    case (st_r.st)
      stop_pkg::ST_RUN:
      begin
        // Entry needs both bits; software pads with no-ops meanwhile
        if (i_power_save_select_bit && i_stop_request_bit)
          st_nxt.st = stop_pkg::ST_STOP;
      end
      stop_pkg::ST_STOP:
      begin
        if (i_reset_pin_wake)
        begin
          // Reset wake uses the reset default interval
          st_nxt.limit = stop_pkg::STAB_CNT_W'(RST_STAB_CYCLES - 1);
          st_nxt.cnt = stop_pkg::STAB_CNT_RST;
          st_nxt.pend = 1'b0;
          // Source is latched: the pin may be released long before the wait ends
          st_nxt.rst_wake = 1'b1;
          st_nxt.nmi_wake = 1'b0;
          st_nxt.st = stop_pkg::ST_STAB;
        end
        else if (wake_any)
        begin
          st_nxt.limit = prog_limit;
          st_nxt.cnt = stop_pkg::STAB_CNT_RST;
          st_nxt.pend = ~higher;
          st_nxt.rst_wake = 1'b0;
          st_nxt.nmi_wake = nmi_s;
          st_nxt.st = stop_pkg::ST_STAB;
        end
      end
      stop_pkg::ST_STAB:
      begin
        // Shared counter runs to overflow before the CPU is let go
        if (st_r.cnt == st_r.limit)
          st_nxt.st = stop_pkg::ST_WAKE;
        else
          st_nxt.cnt = st_r.cnt + 20'h00001;
      end
      stop_pkg::ST_WAKE:
      begin
        st_nxt.done = 1'b1;
        // A reset wake only reports done, like an ordinary reset
        if (!st_r.pend && !st_r.rst_wake)
        begin
          st_nxt.ack = 1'b1;
          // NMI branches always, even if its pin pulse is over; maskable only when enabled
          st_nxt.branch = st_r.nmi_wake | i_irq_globally_enabled;
        end
        st_nxt.st = stop_pkg::ST_RUN;
      end
      default:
        st_nxt.st = stop_pkg::ST_RUN;
    endcase
  end

  // --------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------
  always_ff @(posedge i_sys_clk)
  begin
    if (i_srst)
    begin
      st_r <= '0;
      st_r.st <= stop_pkg::ST_RUN;
      st_r.limit <= stop_pkg::STAB_CNT_RST;
    end
    else
      st_r <= st_nxt;
  end

  // --------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------
  // Gating follows the state; nothing is cleared, so state is retained
  always_comb
  begin
    o_in_stop = (st_r.st == stop_pkg::ST_STOP);
    o_main_osc_en = ~o_in_stop;
    o_sub_osc_en = 1'b1;
    o_cpu_clk_en = (st_r.st == stop_pkg::ST_RUN) || (st_r.st == stop_pkg::ST_WAKE);
    o_periph_clk_en = o_cpu_clk_en;
    o_retain = ~o_cpu_clk_en;
    o_port_hold = ~o_cpu_clk_en;
    // Async wake path is armed only while the main clock is absent
    o_async_wake_arm = o_in_stop;
    // Stop-domain peripherals; full speed in run
    o_timer8_run = o_cpu_clk_en | i_periph_sel.timer8_ext_sel;
    o_subclk_periph_run = o_cpu_clk_en
      | (i_subclock_used & i_periph_sel.sub_sel);
    o_csi_run = o_cpu_clk_en | i_periph_sel.csi_ext_sel;
    o_uart_run = o_cpu_clk_en | i_periph_sel.uart_ext_sel;
    o_wake_ack = st_r.ack;
    o_wake_branch = st_r.branch;
    o_wake_pending = st_r.pend;
    o_wake_done = st_r.done;
  end

  // --------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------
  property p_entry;
    @(posedge i_sys_clk) disable iff (i_srst)
    (st_r.st == stop_pkg::ST_RUN && i_power_save_select_bit && i_stop_request_bit)
      |=> o_in_stop;
  endproperty
  a_entry: assert property (p_entry) else $error("stop not entered");

  property p_no_entry;
    @(posedge i_sys_clk) disable iff (i_srst)
    (st_r.st == stop_pkg::ST_RUN && !i_power_save_select_bit) |=> !o_in_stop;
  endproperty
  a_no_entry: assert property (p_no_entry) else $error("stop entered without select");

  property p_osc;
    @(posedge i_sys_clk) disable iff (i_srst)
    o_in_stop |-> (!o_main_osc_en && o_sub_osc_en && !o_cpu_clk_en);
  endproperty
  a_osc: assert property (p_osc) else $error("clocks wrong in stop");

  property p_wake;
    @(posedge i_sys_clk) disable iff (i_srst)
    (o_in_stop && wake_any) |=> (st_r.st == stop_pkg::ST_STAB);
  endproperty
  a_wake: assert property (p_wake) else $error("wake missed");

  property p_stab;
    @(posedge i_sys_clk) disable iff (i_srst)
    (st_r.st == stop_pkg::ST_STAB && st_r.cnt != st_r.limit) |=> !o_cpu_clk_en;
  endproperty
  a_stab: assert property (p_stab) else $error("cpu clock before stabilization");

  property p_pend;
    @(posedge i_sys_clk) disable iff (i_srst)
    (o_in_stop && !i_reset_pin_wake && wake_any && !higher) |=> o_wake_pending;
  endproperty
  a_pend: assert property (p_pend) else $error("low priority not pending");

  property p_nmi_branch;
    @(posedge i_sys_clk) disable iff (i_srst)
    (st_r.st == stop_pkg::ST_WAKE && !st_r.pend && !st_r.rst_wake && st_r.nmi_wake)
      |=> (o_wake_ack && o_wake_branch);
  endproperty
  a_nmi_branch: assert property (p_nmi_branch) else $error("nmi not taken");

  property p_next_instr;
    @(posedge i_sys_clk) disable iff (i_srst)
    (st_r.st == stop_pkg::ST_WAKE && !st_r.nmi_wake && !i_irq_globally_enabled)
      |=> !o_wake_branch;
  endproperty
  a_next_instr: assert property (p_next_instr) else $error("unwanted branch");

  property p_rst_limit;
    @(posedge i_sys_clk) disable iff (i_srst)
    (o_in_stop && i_reset_pin_wake)
      |=> (st_r.limit == stop_pkg::STAB_CNT_W'(RST_STAB_CYCLES - 1));
  endproperty
  a_rst_limit: assert property (p_rst_limit) else $error("reset wake interval");

  property p_hold;
    @(posedge i_sys_clk) disable iff (i_srst)
    o_in_stop |-> o_port_hold && o_retain;
  endproperty
  a_hold: assert property (p_hold) else $error("ports not held");

  property p_ack;
    @(posedge i_sys_clk) disable iff (i_srst)
    (st_r.st == stop_pkg::ST_WAKE && !st_r.pend && !st_r.rst_wake) |=> o_wake_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("wake not acknowledged");

  property p_rst_seq;
    @(posedge i_sys_clk) disable iff (i_srst)
    (st_r.st == stop_pkg::ST_WAKE && st_r.rst_wake)
      |=> (o_wake_done && !o_wake_ack && !o_wake_branch);
  endproperty
  a_rst_seq: assert property (p_rst_seq) else $error("reset wake took irq");

  property p_timer8;
    @(posedge i_sys_clk) disable iff (i_srst)
    o_in_stop |-> (o_timer8_run == i_periph_sel.timer8_ext_sel);
  endproperty
  a_timer8: assert property (p_timer8) else $error("timer run wrong in stop");

  property p_subclk;
    @(posedge i_sys_clk) disable iff (i_srst)
    o_in_stop |-> (o_subclk_periph_run == (i_subclock_used && i_periph_sel.sub_sel));
  endproperty
  a_subclk: assert property (p_subclk) else $error("subclock run wrong");

  property p_serial;
    @(posedge i_sys_clk) disable iff (i_srst)
    o_in_stop |-> (o_csi_run == i_periph_sel.csi_ext_sel
      && o_uart_run == i_periph_sel.uart_ext_sel);
  endproperty
  a_serial: assert property (p_serial) else $error("serial run wrong in stop");

endmodule // stop_mode_power_control

`default_nettype wire

// ==== bench/cpu_model.sv ====
// Behavioural CPU side that writes the stop request and then idles
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
  // Clock
  input wire logic i_sys_clk,
  // Commands from the bench
  input wire logic i_enter,
  input wire logic i_select,
  // Software control bits
  output logic o_power_save_select_bit,
  output logic o_stop_request_bit
);
  int nop_cnt = 0;
  logic go;
  initial
  begin
    o_power_save_select_bit = 1'b0;
    o_stop_request_bit = 1'b0;
  end
  // One-cycle request write, then five idle slots so nothing else can follow it too soon
  always @(posedge i_sys_clk)
  begin
    go = i_enter && (nop_cnt == 0);
    #1;
    o_power_save_select_bit = i_select;
    o_stop_request_bit = go;
    if (go)
      nop_cnt = 5;
    else if (nop_cnt > 0)
      nop_cnt = nop_cnt - 1;
  end
endmodule // cpu_model
`default_nettype wire

// ==== bench/tb.sv ====
// Self-checking bench for the stop mode power controller
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 1'b0, srst = 1'b1, sel = 1'b0, enter = 1'b0, mode_bit, req;
  logic ien = 1'b0, isr = 1'b0, nmi = 1'b0, pirq = 1'b0, rwake = 1'b0, subu = 1'b0;
  logic [2:0] stab_sel = 3'h0, isr_prio = 3'h0, wprio = 3'h0;
  logic [6:0] pins = 7'h00, mask = 7'h7f;
  stop_pkg::periph_sel_s psel = '0;
  logic main_osc, sub_osc, cpu_clk, per_clk, arm, t8, sub_run, csi, uart;
  logic hold, retain, in_stop, ack, branch, pend, done;
  int mismatches = 0, check_count = 0, hits = 0, kind;
  int seed = 32'h47fb43a4;
  // Clock at 40 MHz
  always #12.5 clk = ~clk;
  cpu_model i_cpu (.i_sys_clk(clk), .i_enter(enter), .i_select(sel),
    .o_power_save_select_bit(mode_bit), .o_stop_request_bit(req));
  // Short reset-wake interval keeps the run brief
  localparam int RST_CYC = 16;
  stop_mode_power_control #(.RST_STAB_CYCLES(RST_CYC)) i_dut (.i_sys_clk(clk), .i_srst(srst),
    .i_power_save_select_bit(mode_bit), .i_stop_request_bit(req),
    .i_osc_stabilization_select_reg(stab_sel), .i_irq_globally_enabled(ien), .i_in_isr(isr),
    .i_isr_prio(isr_prio), .i_nmi_pin(nmi), .i_external_irq_pins(pins), .i_ext_irq_mask(mask),
    .i_periph_irq(pirq), .i_wake_prio(wprio), .i_reset_pin_wake(rwake), .i_periph_sel(psel),
    .i_subclock_used(subu), .o_main_osc_en(main_osc), .o_sub_osc_en(sub_osc),
    .o_cpu_clk_en(cpu_clk), .o_periph_clk_en(per_clk), .o_async_wake_arm(arm),
    .o_timer8_run(t8), .o_subclk_periph_run(sub_run), .o_csi_run(csi), .o_uart_run(uart),
    .o_port_hold(hold), .o_retain(retain), .o_in_stop(in_stop), .o_wake_ack(ack),
    .o_wake_branch(branch), .o_wake_pending(pend), .o_wake_done(done));
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic enter_stop(input logic s);
    sel = s;
    enter = 1'b1;
    tick();
    enter = 1'b0;
    tick();
    check("in_stop", in_stop, s);
  endtask
  // Stop-state outputs, including the peripherals that may keep running
  task automatic check_stop;
    check("main_osc", main_osc, 0);
    check("sub_osc", sub_osc, 1);
    check("cpu_clk", cpu_clk, 0);
    check("per_clk", per_clk, 0);
    check("retain", retain, 1);
    check("port_hold", hold, 1);
    check("wake_arm", arm, 1);
    check("timer8", t8, psel.timer8_ext_sel);
    check("sub_run", sub_run, psel.sub_sel & subu);
    check("csi", csi, psel.csi_ext_sel);
    check("uart", uart, psel.uart_ext_sel);
  endtask
  // Same-clock wakes: one edge to start the wait, lim cycles of wait, one edge for done;
  // pins pass a two-flop synchroniser first and so take two cycles more
  function automatic int exp_wake_cycles(input int kd, input int lim);
    return (kd < 2) ? lim + 4 : lim + 2;
  endfunction
  // On a pin wake, masked pins must not wake first; then the chosen source wakes and the outcome is checked
  task automatic wake(input int kd, input int lim);
    int n;
    int cpu_on;
    int k;
    logic p;
    n = 0;
    cpu_on = 0;
    k = $unsigned($random(seed)) % 7;
    p = isr && (wprio >= isr_prio) && kd != 0;
    if (kd == 1)
    begin
      mask = ~(7'h01 << k);
      pins = ~(7'h01 << k);
      repeat (4) tick();
      check("masked_wake", in_stop, 1);
    end
    nmi = (kd == 0);
    pins = (kd == 1) ? 7'h7f : 7'h00;
    pirq = (kd == 2);
    rwake = (kd == 3);
    while (done !== 1'b1 && n < lim + 40)
    begin
      tick();
      n++;
      if (cpu_clk === 1'b1 && done !== 1'b1)
        cpu_on++;
    end
    check("wake_cycles", n, exp_wake_cycles(kd, lim));
    check("cpu_on_early", cpu_on, 1);
    if (kd == 3)
    begin
      check("rst_ack", {ack, branch, pend, in_stop}, 0);
    end
    else
    begin
      check("pending", pend, p);
      if (kd == 0 || ien)
        check("ack", ack, !p);
      check("branch", branch, (kd == 0) || (ien && !p));
    end
    {nmi, pins, pirq, rwake, mask} = {10'h000, 7'h7f};
    repeat (3) tick();
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (5) tick();
    srst = 1'b0;
    check("rst_state", {cpu_clk, main_osc, in_stop, pend}, 4'hc);
    enter_stop(1'b0);
    nmi = 1'b1;
    repeat (6)
    begin
      tick();
      hits += (done === 1'b1);
    end
    check("idle_wake", hits, 0);
    nmi = 1'b0;
    repeat (3) tick();
    for (int i = 0; i < 14; i++)
    begin
      kind = (i < 4) ? i : $unsigned($random(seed)) % 4;
      stab_sel = 3'($unsigned($random(seed)) % 2);
      {psel, subu, ien, isr, isr_prio, wprio} = 13'($random(seed));
      enter_stop(1'b1);
      check_stop();
      wake(kind, (kind == 3) ? RST_CYC : (int'(stop_pkg::PROG_STAB_BASE) << stab_sel));
    end
    print_verdict();
  end
  // Watchdog well beyond the longest expected run
  initial
  begin
    #2000000;
    mismatches++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
